// ==== core/vcc_clamp_ctrl.sv ====
// Clamp timing control, clock and bias settings, reference trim and
// side converter result readout for a video sampling codec.
// Assumes one core clock; sync_in is an asynchronous pin, the side
// converter results come from logic on the same clock.
//
// Implementation choice: strobed register access.
`include "vcc_clamp_regs.svh"

// Operation
// - each fine clamp has a direction bit, used only while that clamp is on
// - a fine clamp on/off bit runs that clamp for the fine on-time cycles
// - each coarse clamp has a direction bit, used only while that clamp is on
// - a coarse clamp on/off bit runs that clamp for the coarse on-time cycles
// - clearing clock bit 0 disables the internal crystal oscillator
// - setting clock bit 1 doubles all analog bias currents
// - setting clock bit 3 enables duty-cycle equalizer on converter clock only
// - clock bits 5 and 6 select a delay on the core clock
// - reference bits 4 to 6 trim the converter reference voltage
// - eight read-only side results from 0x10, result k shows input k
// - in sync mode enabled clamps start on the chosen sync edge
// - outside sync mode a clamp starts as soon as its bit enables it
// - on/off bits are edge detected; clear before setting again
// - on-time fields give active cycles per line, after sync when synced
// - polarity zero means low sync pulse, one means high sync pulse
module vcc_clamp_ctrl #(
  parameter int ON_TIME_W = 3,
  parameter int SIDE_COUNT = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input vcc_pkg::vcc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic sync_in,
  input wire logic side_inputs_configured,
  input vcc_pkg::vcc_side_results_t side_result,
  output vcc_pkg::vcc_clamp_bank_t fine_clamp,
  output vcc_pkg::vcc_clamp_bank_t coarse_clamp,
  output logic osc_enable,
  output logic bias_double,
  output logic duty_eq_enable,
  output logic [1:0] core_clk_delay,
  output logic [2:0] converter_reference_voltage_trim
);
  import vcc_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] mode_sync_reg;
  logic [7:0] clamp_timing_reg;
  logic [7:0] fine_clamp_setup_reg;
  logic [7:0] coarse_clamp_setup_reg;
  logic [7:0] clock_and_bias_setup_reg;
  logic [7:0] reference_adjust_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic wr_en;
  logic rd_en;

  assign wr_en = ce && bus_req.wr;
  assign rd_en = ce && bus_req.rd;

  // Reserved bits are masked off on write so they always read as zero;
  // this also keeps a careless write to them from reaching the analog side.
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_sync_reg <= `VCC_RST_MODE_SYNC;
      clamp_timing_reg <= `VCC_RST_CLAMP_TIMING;
      fine_clamp_setup_reg <= `VCC_RST_CLAMP;
      coarse_clamp_setup_reg <= `VCC_RST_CLAMP;
      clock_and_bias_setup_reg <= `VCC_RST_CLOCK_BIAS;
      reference_adjust_reg <= `VCC_RST_REF_ADJUST;
    end else if (wr_en) begin
      case (bus_req.addr)
        `VCC_OFS_MODE_SYNC: mode_sync_reg <= bus_req.wdata & `VCC_MASK_MODE_SYNC;
        `VCC_OFS_CLAMP_TIMING: clamp_timing_reg <= bus_req.wdata & `VCC_MASK_CLAMP_TIMING;
        `VCC_OFS_FINE_CLAMP: fine_clamp_setup_reg <= bus_req.wdata & `VCC_MASK_CLAMP;
        `VCC_OFS_COARSE_CLAMP: coarse_clamp_setup_reg <= bus_req.wdata & `VCC_MASK_CLAMP;
        `VCC_OFS_CLOCK_BIAS: clock_and_bias_setup_reg <= bus_req.wdata & `VCC_MASK_CLOCK_BIAS;
        `VCC_OFS_REF_ADJUST: reference_adjust_reg <= bus_req.wdata & `VCC_MASK_REF_ADJUST;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_next = 8'h00;
    case (bus_req.addr)
      `VCC_OFS_MODE_SYNC: rd_data_next = mode_sync_reg;
      `VCC_OFS_CLAMP_TIMING: rd_data_next = clamp_timing_reg;
      `VCC_OFS_FINE_CLAMP: rd_data_next = fine_clamp_setup_reg;
      `VCC_OFS_COARSE_CLAMP: rd_data_next = coarse_clamp_setup_reg;
      `VCC_OFS_CLOCK_BIAS: rd_data_next = clock_and_bias_setup_reg;
      `VCC_OFS_REF_ADJUST: rd_data_next = reference_adjust_reg;
      default: begin
        // Results read zero until the side inputs are configured
        if (bus_req.addr >= `VCC_OFS_SIDE_RESULT &&
            bus_req.addr < `VCC_OFS_SIDE_RESULT + 8'(SIDE_COUNT) &&
            side_inputs_configured) begin
          rd_data_next = side_result[3'(bus_req.addr - `VCC_OFS_SIDE_RESULT)];
        end
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_reg <= 8'h00;
    end else if (ce) begin
      rd_data_reg <= rd_en ? rd_data_next : 8'h00;
    end
  end

  assign rd_data = rd_data_reg;

  // ----------------------------------------------------------------
  // Clock, bias and reference controls
  // ----------------------------------------------------------------
  logic osc_enable_reg;
  logic bias_double_reg;
  logic duty_eq_enable_reg;
  logic [1:0] core_clk_delay_reg;
  logic [2:0] ref_trim_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_enable_reg <= 1'b1;
      bias_double_reg <= 1'b0;
      duty_eq_enable_reg <= 1'b0;
      core_clk_delay_reg <= 2'h0;
      ref_trim_reg <= 3'h0;
    end else if (ce) begin
      osc_enable_reg <= clock_and_bias_setup_reg[`VCC_OSC_EN_BIT];
      bias_double_reg <= clock_and_bias_setup_reg[`VCC_BIAS_DBL_BIT];
      // Converter clock only; core clock path is untouched
      duty_eq_enable_reg <= clock_and_bias_setup_reg[`VCC_DUTY_EQ_BIT];
      core_clk_delay_reg <= clock_and_bias_setup_reg[`VCC_CLK_DLY_LSB +: 2];
      ref_trim_reg <= reference_adjust_reg[`VCC_REF_TRIM_LSB +: 3];
    end
  end

  assign osc_enable = osc_enable_reg;
  assign bias_double = bias_double_reg;
  assign duty_eq_enable = duty_eq_enable_reg;
  assign core_clk_delay = core_clk_delay_reg;
  assign converter_reference_voltage_trim = ref_trim_reg;

  // ----------------------------------------------------------------
  // Sync input: two-flop synchroniser then edge detect
  // ----------------------------------------------------------------
  logic sync_meta_reg;
  logic sync_stable_reg;
  logic sync_prev_reg;
  logic sync_edge;
  logic sync_pol;
  logic clamp_sync_select;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_meta_reg <= 1'b0;
      sync_stable_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else if (ce) begin
      sync_meta_reg <= sync_in;
      sync_stable_reg <= sync_meta_reg;
      sync_prev_reg <= sync_stable_reg;
    end
  end

  assign sync_pol = mode_sync_reg[`VCC_SYNC_POL_BIT];
  assign clamp_sync_select = clamp_timing_reg[`VCC_CLAMP_SYNC_BIT];

  // Leading edge of the sync pulse: falling for low pulses, rising for high
  assign sync_edge = sync_pol ? (sync_stable_reg && !sync_prev_reg)
                              : (!sync_stable_reg && sync_prev_reg);

  // ----------------------------------------------------------------
  // Clamp channels: 0-2 fine, 3-5 coarse
  // ----------------------------------------------------------------
  logic [5:0] onoff_bits;
  logic [5:0] dir_bits;
  logic [5:0] onoff_prev_reg;
  logic [5:0] clamp_on;
  logic [5:0] clamp_up;
  logic [ON_TIME_W-1:0] fine_on_time;
  logic [ON_TIME_W-1:0] coarse_on_time;

  assign fine_on_time = clamp_timing_reg[`VCC_FINE_TIME_LSB +: ON_TIME_W];
  assign coarse_on_time = clamp_timing_reg[`VCC_COARSE_TIME_LSB +: ON_TIME_W];

  always_ff @(posedge clk) begin
    if (reset) begin
      onoff_prev_reg <= 6'h00;
    end else if (ce) begin
      onoff_prev_reg <= onoff_bits;
    end
  end

  for (genvar i = 0; i < 6; i++) begin : g_clamp
    localparam int POS = 2 * (i % 3);
    logic [7:0] setup;
    logic [ON_TIME_W-1:0] on_time;
    logic [ON_TIME_W-1:0] count_reg;
    logic armed_reg;
    logic on_reg;
    logic up_reg;
    logic rise;
    logic start;

    assign setup = (i < 3) ? fine_clamp_setup_reg : coarse_clamp_setup_reg;
    assign on_time = (i < 3) ? fine_on_time : coarse_on_time;
    assign onoff_bits[i] = setup[POS + 1];
    assign dir_bits[i] = setup[POS];
    assign rise = onoff_bits[i] && !onoff_prev_reg[i];

    // Unsynced start on the bit's rising edge; synced start waits for sync
    assign start = clamp_sync_select ? (sync_edge && (armed_reg || rise))
                                     : rise;

    // A pending activation is dropped if sync mode is left or bit cleared
    always_ff @(posedge clk) begin
      if (reset) begin
        armed_reg <= 1'b0;
      end else if (ce) begin
        if (start || !clamp_sync_select || !onoff_bits[i]) begin
          armed_reg <= 1'b0;
        end else if (rise) begin
          armed_reg <= 1'b1;
        end
      end
    end

    // Clamp is held for exactly on_time cycles; zero means no pulse
    always_ff @(posedge clk) begin
      if (reset) begin
        count_reg <= '0;
        on_reg <= 1'b0;
      end else if (ce) begin
        if (start) begin
          count_reg <= on_time;
          on_reg <= (on_time != '0);
        end else if (count_reg > ON_TIME_W'(1)) begin
          count_reg <= count_reg - ON_TIME_W'(1);
        end else begin
          count_reg <= '0;
          on_reg <= 1'b0;
        end
      end
    end

    // Direction only drives out while the clamp is active
    always_ff @(posedge clk) begin
      if (reset) begin
        up_reg <= 1'b0;
      end else if (ce) begin
        up_reg <= dir_bits[i] && (start ? (on_time != '0) : (count_reg > ON_TIME_W'(1)));
      end
    end

    assign clamp_on[i] = on_reg;
    assign clamp_up[i] = up_reg;
  end

  assign fine_clamp.on = clamp_on[2:0];
  assign fine_clamp.up = clamp_up[2:0];
  assign coarse_clamp.on = clamp_on[5:3];
  assign coarse_clamp.up = clamp_up[5:3];

endmodule : vcc_clamp_ctrl

// ==== core/vcc_clamp_regs.svh ====
// Register offsets, field positions, write masks and reset values
// for the clamp timing control block.
// Assumes an 8-bit register port with byte addresses.
`ifndef VCC_CLAMP_REGS_SVH
`define VCC_CLAMP_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define VCC_OFS_MODE_SYNC       8'h03
`define VCC_OFS_CLAMP_TIMING    8'h07
`define VCC_OFS_FINE_CLAMP      8'h08
`define VCC_OFS_COARSE_CLAMP    8'h09
`define VCC_OFS_CLOCK_BIAS      8'h0a
`define VCC_OFS_REF_ADJUST      8'h0b
`define VCC_OFS_SIDE_RESULT     8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VCC_SYNC_POL_BIT        5
`define VCC_FINE_TIME_LSB       0
`define VCC_COARSE_TIME_LSB     3
`define VCC_CLAMP_SYNC_BIT      6
`define VCC_OSC_EN_BIT          0
`define VCC_BIAS_DBL_BIT        1
`define VCC_DUTY_EQ_BIT         3
`define VCC_CLK_DLY_LSB         5
`define VCC_REF_TRIM_LSB        4

// ----------------------------------------------------------------
// Writable bit masks; other bits read as zero
// ----------------------------------------------------------------
`define VCC_MASK_MODE_SYNC      8'h20
`define VCC_MASK_CLAMP_TIMING   8'h7f
`define VCC_MASK_CLAMP          8'h3f
`define VCC_MASK_CLOCK_BIAS     8'h6b
`define VCC_MASK_REF_ADJUST     8'h7f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VCC_RST_MODE_SYNC       8'h00
`define VCC_RST_CLAMP_TIMING    8'h00
`define VCC_RST_CLAMP           8'h00
`define VCC_RST_CLOCK_BIAS      8'h01
`define VCC_RST_REF_ADJUST      8'h01

`endif

// ==== core/vcc_pkg.sv ====
// Types shared by the clamp timing control block and its bench.
// Assumes the 8-bit register port described in the top module.
package vcc_pkg;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } vcc_bus_req_t;

  // ----------------------------------------------------------------
  // One bank of three clamps: enable and drive direction
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] on;
    logic [2:0] up;
  } vcc_clamp_bank_t;

  typedef logic [7:0][7:0] vcc_side_results_t;

endpackage : vcc_pkg

// ==== testbench/vcc_clamp_ctrl_bench.sv ====
// Self-checking bench for the clamp timing control block.
// Assumes the port checker is bound in from its own file.
module vcc_clamp_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import vcc_pkg::*;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, sync_in = 1'b1, side_inputs_configured = 1'b1;
  vcc_bus_req_t bus_req = '0;
  vcc_side_results_t side_result = '0;
  vcc_clamp_bank_t fine_clamp, coarse_clamp;
  logic [7:0] rd_data;
  logic osc_enable, bias_double, duty_eq_enable;
  logic [1:0] core_clk_delay;
  logic [2:0] trim;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  logic [7:0] exp_q[$];
  logic last_rd = 1'b0;
  // Address in the high byte, writable mask in the low byte
  logic [15:0] tbl [6] = '{16'h0320, 16'h077f, 16'h083f, 16'h093f, 16'h0a6b, 16'h0b7f};

  initial forever #10 clk = ~clk;

  vcc_clamp_ctrl dut_u (.clk(clk), .reset(reset), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
    .sync_in(sync_in), .side_inputs_configured(side_inputs_configured), .side_result(side_result),
    .fine_clamp(fine_clamp), .coarse_clamp(coarse_clamp), .osc_enable(osc_enable),
    .bias_double(bias_double), .duty_eq_enable(duty_eq_enable), .core_clk_delay(core_clk_delay),
    .converter_reference_voltage_trim(trim));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task chk_rd(input logic [7:0] got, input logic [7:0] want);
    cmp_count++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: read %h want %h", $time, got, want);
    end
  endtask : chk_rd
  task chk_len(input int got, input int want);
    cmp_count++;
    if (got != want) begin
      miscompares++;
      $display("unexpected at %0t: count %0d want %0d", $time, got, want);
    end
  endtask : chk_len
  always @(posedge clk) last_rd <= bus_req.rd;
  // Read data stands only in the cycle after the strobe
  always @(negedge clk) if (last_rd) chk_rd(rd_data, exp_q.pop_front());
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      $display("unexpected at %0t: run did not finish in time", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Bus and clamp tasks
  // ----------------------------------------------------------------
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
  endtask : acc
  task rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    acc(1'b0, a, 8'h00);
  endtask : rd
  // Counts active and drive-up cycles of one clamp over a fixed window
  task measure(input int bank, input int idx, input int n, input int dir);
    int on_c, up_c;
    on_c = 0;
    up_c = 0;
    bus_req <= '0;
    @(posedge clk);
    repeat (12) begin
      @(negedge clk);
      on_c += ((bank ? coarse_clamp.on[idx] : fine_clamp.on[idx]) === 1'b1);
      up_c += ((bank ? coarse_clamp.up[idx] : fine_clamp.up[idx]) === 1'b1);
    end
    @(posedge clk);
    chk_len(on_c, n);
    chk_len(up_c, dir ? n : 0);
  endtask : measure

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] dv [6];
    int n, dir;
    void'($urandom(33));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd(tbl[i][15:8], (i > 3) ? 8'h01 : 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom) & tbl[i][7:0];
      if (i == 5) d = (d & 8'h70) | 8'h01;
      dv[i] = d;
      acc(1'b1, tbl[i][15:8], d);
      rd(tbl[i][15:8], d & tbl[i][7:0]);
    end
    // Writes are frozen while the clock enable is low
    ce <= 1'b0;
    acc(1'b1, 8'h0b, dv[5] ^ 8'h70);
    ce <= 1'b1;
    rd(8'h0b, dv[5]);
    for (int i = 0; i < 8; i++) side_result[i] <= 8'($urandom);
    acc(1'b1, 8'h10, 8'h5a);
    for (int i = 0; i < 8; i++) rd(8'(8'h10 + i), side_result[i]);
    side_inputs_configured <= 1'b0;
    rd(8'h13, 8'h00);
    side_inputs_configured <= 1'b1;
    rd(8'h20, 8'h00);
    acc(1'b1, 8'h08, 8'h00);
    acc(1'b1, 8'h09, 8'h00);
    repeat (10) rd(8'h00, 8'h00);
    chk_rd({trim, core_clk_delay, duty_eq_enable, bias_double, osc_enable},
      {dv[5][6:4], dv[4][6:5], dv[4][3], dv[4][1:0]});
    for (int i = 0; i < 6; i++) begin
      n = $urandom_range(7, 1);
      dir = $urandom_range(1, 0);
      acc(1'b1, 8'h07, (i < 3) ? 8'(n) : 8'(n << 3));
      d = 8'((2 + dir) << (2 * (i % 3)));
      acc(1'b1, 8'(8'h08 + i / 3), d);
      measure(i / 3, i % 3, n, dir);
      acc(1'b1, 8'(8'h08 + i / 3), d);
      measure(i / 3, i % 3, 0, 0);
      acc(1'b1, 8'(8'h08 + i / 3), 8'h00);
    end
    for (int p = 0; p < 2; p++) begin
      acc(1'b1, 8'h03, 8'(p << 5));
      sync_in <= p[0];
      acc(1'b1, 8'h07, 8'h43);
      acc(1'b1, 8'h08, 8'h00);
      acc(1'b1, 8'h08, 8'h02);
      // Trailing edge of the pulse must not start an armed clamp
      sync_in <= !p[0];
      measure(0, 0, 0, 0);
      sync_in <= p[0];
      measure(0, 0, 3, 0);
    end
    chk_len(exp_q.size(), 0);
    give_verdict();
  end
endmodule : vcc_clamp_ctrl_bench

// ==== testbench/vcc_clamp_ctrl_properties.sv ====
// Port checker for the clamp timing control block.
// Assumes ce stays high around each watched write.
module vcc_clamp_ctrl_properties
  import vcc_pkg::*;
#(
  parameter int ON_TIME_W = 3,
  parameter int SIDE_COUNT = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input vcc_pkg::vcc_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic side_inputs_configured,
  input vcc_pkg::vcc_side_results_t side_result,
  input vcc_pkg::vcc_clamp_bank_t fine_clamp,
  input vcc_pkg::vcc_clamp_bank_t coarse_clamp,
  input wire logic osc_enable,
  input wire logic bias_double,
  input wire logic duty_eq_enable,
  input wire logic [1:0] core_clk_delay,
  input wire logic [2:0] converter_reference_voltage_trim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Shadow of the on-time register and run lengths of clamp 0
  // ----------------------------------------------------------------
  logic [6:0] time_reg;
  logic [3:0] fine_run;
  logic [3:0] coarse_run;
  always_ff @(posedge clk) begin
    if (reset) time_reg <= 7'h00;
    else if (ce && bus_req.wr && bus_req.addr == 8'h07) time_reg <= bus_req.wdata[6:0];
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      fine_run <= 4'h0;
      coarse_run <= 4'h0;
    end else if (ce) begin
      fine_run <= fine_clamp.on[0] ? fine_run + 4'h1 : 4'h0;
      coarse_run <= coarse_clamp.on[0] ? coarse_run + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_wr(a);
    ce && bus_req.wr && bus_req.addr == a ##1 ce;
  endsequence
  property p_osc; s_wr(8'h0a) |=> osc_enable == $past(bus_req.wdata[0], 2); endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  property p_bias; s_wr(8'h0a) |=> bias_double == $past(bus_req.wdata[1], 2); endproperty
  a_bias: assert property (p_bias) else $error("bias double wrong");
  property p_duty; s_wr(8'h0a) |=> duty_eq_enable == $past(bus_req.wdata[3], 2); endproperty
  a_duty: assert property (p_duty) else $error("duty equalizer wrong");
  property p_dly; s_wr(8'h0a) |=> core_clk_delay == $past(bus_req.wdata[6:5], 2); endproperty
  a_dly: assert property (p_dly) else $error("core clock delay wrong");
  property p_trim;
    s_wr(8'h0b) |=> converter_reference_voltage_trim == $past(bus_req.wdata[6:4], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("reference trim wrong");
  property p_idle; ce && !bus_req.rd |=> rd_data == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_side;
    ce && bus_req.rd && bus_req.addr[7:3] == 5'h02 && side_inputs_configured
      |=> rd_data == $past(side_result[bus_req.addr[2:0]]);
  endproperty
  a_side: assert property (p_side) else $error("side result wrong");
  property p_gate;
    (fine_clamp.up & ~fine_clamp.on) == 3'h0 && (coarse_clamp.up & ~coarse_clamp.on) == 3'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("direction while off");
  property p_fine; $fell(fine_clamp.on[0]) |-> fine_run == {1'b0, time_reg[2:0]}; endproperty
  a_fine: assert property (p_fine) else $error("fine pulse length");
  property p_coarse; $fell(coarse_clamp.on[0]) |-> coarse_run == {1'b0, time_reg[5:3]}; endproperty
  a_coarse: assert property (p_coarse) else $error("coarse pulse length");
endmodule : vcc_clamp_ctrl_properties

bind vcc_clamp_ctrl vcc_clamp_ctrl_properties #(.ON_TIME_W(ON_TIME_W), .SIDE_COUNT(SIDE_COUNT)) chk_u (
  .clk(clk), .reset(reset), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
  .side_inputs_configured(side_inputs_configured), .side_result(side_result),
  .fine_clamp(fine_clamp), .coarse_clamp(coarse_clamp), .osc_enable(osc_enable),
  .bias_double(bias_double), .duty_eq_enable(duty_eq_enable), .core_clk_delay(core_clk_delay),
  .converter_reference_voltage_trim(converter_reference_voltage_trim)
);
